// ===== charger_map.svh
// Register map, field positions and timing counts of the charger link
`ifndef CHARGER_MAP_SVH
`define CHARGER_MAP_SVH
`define DEV_ADDR 7'h09
`define CMD_CURRENT 8'h14
`define CMD_VOLTAGE 8'h15
`define CMD_MAKER 8'hfe
`define CMD_PART 8'hff
`define VOLT_MSB 14
`define VOLT_LSB 4
`define CURR_MSB 12
`define CURR_LSB 7
// Lowest code that reaches 4.095 V at 16 mV a step
`define VOLT_MIN_CODE 11'h100
`define REG_RESET 16'h0000
`define OC_LATCH_LIMIT 3'h3
`define CLK_PERIOD_NS 25
`define SCL_PERIOD_NS 1000
`define SCL_QUARTER_CYC (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`define HOST_CTRL 4'h0
`define HOST_DATA 4'h1
`define HOST_STATUS 4'h2
`define CTRL_READ_BIT 8
`endif

// ===== charger_pkg.sv
// Types shared by both ends of the charger link
package charger_pkg;
	typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_ACK, SL_TX, SL_MACK} slave_state_type;
	typedef enum logic [1:0] {K_START, K_WBYTE, K_RBYTE, K_STOP} step_kind_type;
endpackage : charger_pkg

// ===== smbus_link_if.sv
// Open-drain two-wire link between bus master and charger slave
`timescale 1ns/1ps
`default_nettype none
interface smbus_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// Pull-ups win unless someone drives low
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport device(input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host(input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface : smbus_link_if
`default_nettype wire

// ===== charger_slave.sv
// Charger management slave: two-wire register port and fault shutdown
// Function
// - Thermal fault latches full shutdown until reinsertion
// - Over three overcurrents latch; else shutdown unlatched
// - Slave only at address 0x09
// - Only write-word and read-word transfers
// - Two read-only identifiers at 0xFE, 0xFF
// - Disabled charger loses all register contents
// - SDA falling with SCL high starts
// - SDA rising with SCL high stops
// - SDA changes only while SCL low
// - Eight-bit bytes sampled on SCL rise
// - Ninth clock carries receiver acknowledge
// - Identifiers always return fixed codes
// - Charge voltage register at 0x15
// - Voltage 4.095 to 19.2 V, 16 mV; code accepts any 11-bit code, up to 32.752 V
// - Setting below 4.095 V stops charging
// - Reset clears settings; off until both written
// - Gate drivers low until restarted
// - Voltage field bits 14:4, rest zero
// - Current at 0x14, bits 12:7, rest zero
`timescale 1ns/1ps
`default_nettype none
`include "charger_map.svh"
module charger_slave import charger_pkg::*; #(
	// Arbitrary identification values
	parameter logic [15:0] MAKER_ID = 16'h0a5c,
	parameter logic [15:0] PART_ID = 16'h0031
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Two-wire link
	smbus_link_if.device link,
	// Charger status pins
	input wire logic charger_enable,
	input wire logic adapter_present,
	input wire logic thermal_fault,
	input wire logic adapter_overvoltage_fault,
	input wire logic adapter_overcurrent_fault,
	input wire logic pwm_demand,
	// Power stage controls
	output logic charging,
	output logic pass_switch_drive,
	output logic analog_rail,
	output logic gate_supply,
	output logic high_side_gate,
	output logic low_side_gate,
	output logic [10:0] voltage_code,
	output logic [5:0] current_code
);
	logic [7:0] meta_ff;
	logic [7:0] sync_ff;
	logic [2:0] prev_ff;
	logic scl_s, sda_s, en_s, adapter_s, thermal_s, ovp_s, ocp_s, pwm_s;
	logic scl_rise, scl_fall, start_seen, stop_seen, ocp_rise;
	slave_state_type state_ff;
	logic [3:0] bit_cnt_ff;
	logic [2:0] byte_idx_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic [7:0] cmd_ff;
	logic [7:0] lo_ff;
	logic read_ff, hi_ff, mack_ok_ff, sda_low_ff;
	logic rx_done, byte_ok, word_wr;
	logic [15:0] rd_word;
	logic [15:0] wr_word;
	logic [10:0] volt_ff;
	logic [5:0] curr_ff;
	logic volt_set_ff, curr_set_ff;
	logic thermal_latch_ff, oc_latch_ff;
	logic [2:0] oc_cnt_ff;
	logic latched, soft_fault, wipe, run;
	logic charging_ff, pass_ff, rail_ff, hs_ff, ls_ff;

	// Every pin passes two flops before use
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			// Link lines rest high, so no false edge is seen after reset
			meta_ff <= 8'hc0;
			sync_ff <= 8'hc0;
			prev_ff <= 3'h6;
		end else begin
			meta_ff <= {link.scl, link.sda, charger_enable, adapter_present, thermal_fault,
				adapter_overvoltage_fault, adapter_overcurrent_fault, pwm_demand};
			sync_ff <= meta_ff;
			prev_ff <= {scl_s, sda_s, ocp_s};
		end
	end

	assign {scl_s, sda_s, en_s, adapter_s, thermal_s, ovp_s, ocp_s, pwm_s} = sync_ff;
	assign scl_rise = scl_s & ~prev_ff[2];
	assign scl_fall = ~scl_s & prev_ff[2];
	assign start_seen = scl_s & prev_ff[2] & ~sda_s & prev_ff[1];
	assign stop_seen = scl_s & prev_ff[2] & sda_s & ~prev_ff[1];
	assign ocp_rise = ocp_s & ~prev_ff[0];

	assign rx_done = (state_ff == SL_RX) && scl_fall && (bit_cnt_ff == 4'h8);
	// Byte 0 address, 1 command, 2 low data, 3 high data; a fifth byte is refused
	always_comb begin
		unique case (byte_idx_ff)
			3'h0: byte_ok = (shift_ff[7:1] == `DEV_ADDR);
			3'h1, 3'h2, 3'h3: byte_ok = ~read_ff;
			default: byte_ok = 1'b0;
		endcase
	end
	assign word_wr = rx_done && (byte_idx_ff == 3'h3) && ~read_ff;
	assign wr_word = {shift_ff, lo_ff};

	always_comb begin
		unique case (cmd_ff)
			`CMD_VOLTAGE: rd_word = {1'b0, volt_ff, 4'h0};
			`CMD_CURRENT: rd_word = {3'h0, curr_ff, 7'h00};
			`CMD_MAKER: rd_word = MAKER_ID;
			`CMD_PART: rd_word = PART_ID;
			default: rd_word = `REG_RESET;
		endcase
	end

	// Byte engine; data moves only after a sensed SCL fall
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_ff <= SL_IDLE;
			bit_cnt_ff <= 4'h0;
			byte_idx_ff <= 3'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			read_ff <= 1'b0;
			hi_ff <= 1'b0;
			mack_ok_ff <= 1'b0;
			sda_low_ff <= 1'b0;
		end else if (start_seen) begin
			state_ff <= SL_RX;
			bit_cnt_ff <= 4'h0;
			byte_idx_ff <= 3'h0;
			read_ff <= 1'b0;
			sda_low_ff <= 1'b0;
		end else if (stop_seen) begin
			state_ff <= SL_IDLE;
			sda_low_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				SL_IDLE: begin
					sda_low_ff <= 1'b0;
				end
				SL_RX: begin
					if (scl_rise && bit_cnt_ff != 4'h8) begin
						shift_ff <= {shift_ff[6:0], sda_s};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (rx_done) begin
						bit_cnt_ff <= 4'h0;
						if (byte_idx_ff == 3'h0) begin
							read_ff <= shift_ff[0];
						end
						if (byte_ok) begin
							state_ff <= SL_ACK;
							sda_low_ff <= 1'b1;
						end else begin
							state_ff <= SL_IDLE;
						end
					end
				end
				SL_ACK: begin
					if (scl_fall) begin
						byte_idx_ff <= byte_idx_ff + 3'h1;
						if (read_ff) begin
							state_ff <= SL_TX;
							tx_ff <= rd_word[7:0];
							sda_low_ff <= ~rd_word[7];
							hi_ff <= 1'b0;
						end else begin
							state_ff <= SL_RX;
							sda_low_ff <= 1'b0;
						end
					end
				end
				SL_TX: begin
					if (scl_fall) begin
						if (bit_cnt_ff == 4'h7) begin
							state_ff <= SL_MACK;
							bit_cnt_ff <= 4'h0;
							sda_low_ff <= 1'b0;
						end else begin
							tx_ff <= {tx_ff[6:0], 1'b0};
							sda_low_ff <= ~tx_ff[6];
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end
					end
				end
				SL_MACK: begin
					if (scl_rise) begin
						mack_ok_ff <= ~sda_s & ~hi_ff;
					end else if (scl_fall) begin
						if (mack_ok_ff) begin
							state_ff <= SL_TX;
							tx_ff <= rd_word[15:8];
							sda_low_ff <= ~rd_word[15];
							hi_ff <= 1'b1;
						end else begin
							state_ff <= SL_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Device only pulls low; it never drives a start of its own
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = sda_low_ff;

	// Settings registers; the link keeps no supply of its own while disabled
	assign wipe = ~adapter_s | ~en_s | latched;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cmd_ff <= 8'h00;
			lo_ff <= 8'h00;
		end else if (rx_done && byte_idx_ff == 3'h1) begin
			cmd_ff <= shift_ff;
		end else if (rx_done && byte_idx_ff == 3'h2) begin
			lo_ff <= shift_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || wipe) begin
			volt_ff <= 11'h000;
			curr_ff <= 6'h00;
			volt_set_ff <= 1'b0;
			curr_set_ff <= 1'b0;
		end else if (word_wr && cmd_ff == `CMD_VOLTAGE) begin
			volt_ff <= wr_word[`VOLT_MSB:`VOLT_LSB];
			volt_set_ff <= 1'b1;
		end else if (word_wr && cmd_ff == `CMD_CURRENT) begin
			curr_ff <= wr_word[`CURR_MSB:`CURR_LSB];
			curr_set_ff <= 1'b1;
		end
	end

	// Fault latches clear only on reset or while the adapter is away
	always_ff @(posedge ref_clk) begin
		if (!rstn || !adapter_s) begin
			thermal_latch_ff <= 1'b0;
			oc_latch_ff <= 1'b0;
			oc_cnt_ff <= 3'h0;
		end else begin
			if (thermal_s) begin
				thermal_latch_ff <= 1'b1;
			end
			if (ocp_rise && oc_cnt_ff != 3'h7) begin
				oc_cnt_ff <= oc_cnt_ff + 3'h1;
			end
			if (oc_cnt_ff > `OC_LATCH_LIMIT) begin
				oc_latch_ff <= 1'b1;
			end
		end
	end

	assign latched = thermal_latch_ff | oc_latch_ff;
	assign soft_fault = ovp_s | ocp_s;
	assign run = adapter_s & en_s & ~latched & ~soft_fault & volt_set_ff & curr_set_ff
		& (volt_ff >= `VOLT_MIN_CODE) & (curr_ff != 6'h00);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			charging_ff <= 1'b0;
			pass_ff <= 1'b0;
			rail_ff <= 1'b0;
			hs_ff <= 1'b0;
			ls_ff <= 1'b0;
		end else begin
			charging_ff <= run;
			pass_ff <= adapter_s & ~latched & ~soft_fault;
			rail_ff <= adapter_s & ~latched;
			hs_ff <= run & pwm_s;
			ls_ff <= run & ~pwm_s;
		end
	end

	assign charging = charging_ff;
	assign pass_switch_drive = pass_ff;
	assign analog_rail = rail_ff;
	assign gate_supply = rail_ff;
	assign high_side_gate = hs_ff;
	assign low_side_gate = ls_ff;
	assign voltage_code = volt_ff;
	assign current_code = curr_ff;
endmodule : charger_slave
`default_nettype wire

// ===== charger_master.sv
// Bus master end: runs write-word and read-word transfers on software order
`timescale 1ns/1ps
`default_nettype none
`include "charger_map.svh"
module charger_master import charger_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Two-wire link
	smbus_link_if.host link,
	// Software register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata
);
	localparam logic [5:0] QUARTER = 6'(`SCL_QUARTER_CYC);
	logic [5:0] q_cnt_ff;
	logic [1:0] phase_ff;
	logic [3:0] bit_ff;
	logic [2:0] step_ff;
	logic [7:0] cmd_ff;
	logic [15:0] wdata_ff;
	logic [15:0] result_ff;
	logic [7:0] rx_ff;
	logic rd_mode_ff, busy_ff, nack_ff, scl_low_ff, sda_low_ff;
	logic [1:0] sda_sync_ff;
	logic tick, tx_bit;
	step_kind_type kind;
	logic [7:0] tx_byte;
	logic [15:0] rdata_ff;

	// Step list: write S A C L H P, read S A C S A' L H P
	always_comb begin
		kind = K_WBYTE;
		tx_byte = 8'h00;
		unique case (step_ff)
			3'h0: kind = K_START;
			3'h1: tx_byte = {`DEV_ADDR, 1'b0};
			3'h2: tx_byte = cmd_ff;
			3'h3: begin
				kind = rd_mode_ff ? K_START : K_WBYTE;
				tx_byte = wdata_ff[7:0];
			end
			3'h4: tx_byte = rd_mode_ff ? {`DEV_ADDR, 1'b1} : wdata_ff[15:8];
			3'h5: kind = rd_mode_ff ? K_RBYTE : K_STOP;
			3'h6: kind = K_RBYTE;
			3'h7: kind = K_STOP;
		endcase
	end
	assign tx_bit = tx_byte[3'h7 - bit_ff[2:0]];
	assign tick = busy_ff && (q_cnt_ff == QUARTER - 6'h01);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sda_sync_ff <= 2'h3;
		end else begin
			sda_sync_ff <= {sda_sync_ff[0], link.sda};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || tick || !busy_ff) begin
			q_cnt_ff <= 6'h00;
		end else begin
			q_cnt_ff <= q_cnt_ff + 6'h01;
		end
	end

	// Quarter phases: 0 set SDA, 1 raise SCL, 2 sample, 3 lower SCL
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			phase_ff <= 2'h0;
			bit_ff <= 4'h0;
			step_ff <= 3'h0;
			busy_ff <= 1'b0;
			nack_ff <= 1'b0;
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			rx_ff <= 8'h00;
			result_ff <= 16'h0000;
			cmd_ff <= 8'h00;
			rd_mode_ff <= 1'b0;
		end else if (!busy_ff) begin
			if (reg_wr && reg_addr == `HOST_CTRL) begin
				cmd_ff <= reg_wdata[7:0];
				rd_mode_ff <= reg_wdata[`CTRL_READ_BIT];
				busy_ff <= 1'b1;
				nack_ff <= 1'b0;
				step_ff <= 3'h0;
				phase_ff <= 2'h0;
				bit_ff <= 4'h0;
			end
		end else if (tick) begin
			phase_ff <= phase_ff + 2'h1;
			unique case (phase_ff)
				2'h0: begin
					unique case (kind)
						K_START: sda_low_ff <= 1'b0;
						K_STOP: sda_low_ff <= 1'b1;
						K_WBYTE: sda_low_ff <= (bit_ff != 4'h8) && !tx_bit;
						K_RBYTE: sda_low_ff <= (bit_ff == 4'h8) && (step_ff == 3'h5);
					endcase
				end
				2'h1: scl_low_ff <= 1'b0;
				2'h2: begin
					if (kind == K_START) begin
						sda_low_ff <= 1'b1;
					end else if (kind == K_STOP) begin
						sda_low_ff <= 1'b0;
						busy_ff <= 1'b0;
					end else if (bit_ff != 4'h8) begin
						rx_ff <= {rx_ff[6:0], sda_sync_ff[1]};
						if (bit_ff == 4'h7 && step_ff == 3'h5) begin
							result_ff[7:0] <= {rx_ff[6:0], sda_sync_ff[1]};
						end
						if (bit_ff == 4'h7 && step_ff == 3'h6) begin
							result_ff[15:8] <= {rx_ff[6:0], sda_sync_ff[1]};
						end
					end else if (kind == K_WBYTE && sda_sync_ff[1]) begin
						nack_ff <= 1'b1;
					end
				end
				2'h3: begin
					scl_low_ff <= 1'b1;
					if (kind == K_START || bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						// A refused byte goes straight to the stop
						step_ff <= nack_ff ? (rd_mode_ff ? 3'h7 : 3'h5) : step_ff + 3'h1;
					end else begin
						bit_ff <= bit_ff + 4'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wdata_ff <= 16'h0000;
		end else if (reg_wr && reg_addr == `HOST_DATA && !busy_ff) begin
			wdata_ff <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rdata_ff <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`HOST_CTRL: rdata_ff <= {7'h00, rd_mode_ff, cmd_ff};
				`HOST_DATA: rdata_ff <= rd_mode_ff ? result_ff : wdata_ff;
				`HOST_STATUS: rdata_ff <= {14'h0000, nack_ff, busy_ff};
				default: rdata_ff <= 16'h0000;
			endcase
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	assign reg_rdata = rdata_ff;
	assign link.host_scl_o = 1'b0;
	assign link.host_scl_oe = scl_low_ff;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = sda_low_ff;
endmodule : charger_master
`default_nettype wire

// ===== charger_assertions.sv
// Protocol checker watching the two-wire link between master and charger
`timescale 1ns/1ps
`default_nettype none
`include "charger_map.svh"
module charger_assertions (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Link signals
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_ff, sda_ff, busy_ff, rd_ff;
	logic [3:0] bit_ff;
	logic [2:0] byte_ff;
	logic [7:0] shift_ff;
	logic rise, start_ev, stop_ev, ack_slot;
	assign rise = scl & ~scl_ff;
	assign start_ev = scl & scl_ff & sda_ff & ~sda;
	assign stop_ev = scl & scl_ff & ~sda_ff & sda;
	assign ack_slot = rise & (bit_ff == 4'h8);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge ref_clk) begin
		scl_ff <= rstn ? scl : 1'b1;
		sda_ff <= rstn ? sda : 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn || stop_ev) busy_ff <= 1'b0;
		else if (start_ev) busy_ff <= 1'b1;
	end
	// Counts restart on every start, so a repeated start reopens address decoding
	always_ff @(posedge ref_clk) begin
		if (!rstn || start_ev) begin
			bit_ff <= 4'h0;
			byte_ff <= 3'h0;
		end else if (ack_slot) begin
			bit_ff <= 4'h0;
			byte_ff <= byte_ff + 3'h1;
		end else if (rise) begin
			bit_ff <= bit_ff + 4'h1;
			shift_ff <= {shift_ff[6:0], sda};
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn) rd_ff <= 1'b0;
		else if (ack_slot && byte_ff == 3'h0) rd_ff <= shift_ff[0];
	end
	a_dev_sda_quiet: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
		else $error("device moved data while clock high");
	a_host_sda_edge: assert property ($changed(host_sda_oe) && scl && $past(scl)
		|-> (start_ev || stop_ev))
		else $error("master moved data while clock high outside start or stop");
	a_no_unsolicited: assert property (!busy_ff |-> !dev_sda_oe)
		else $error("device drove data outside a transfer");
	a_addr_ack: assert property (ack_slot && byte_ff == 3'h0 && shift_ff[7:1] == `DEV_ADDR |-> !sda)
		else $error("own address not acknowledged");
	a_write_ack: assert property (ack_slot && !rd_ff && byte_ff inside {3'h1, 3'h2, 3'h3} |-> !sda)
		else $error("written byte not acknowledged");
	a_read_lo_ack: assert property (ack_slot && rd_ff && byte_ff == 3'h1 |-> !sda)
		else $error("low read byte not acknowledged by master");
	a_read_hi_nack: assert property (ack_slot && rd_ff && byte_ff == 3'h2 |-> sda)
		else $error("final read byte acknowledged");
	a_clock_high_len: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	a_start_clocks: assert property (start_ev |-> ##[1:30] !scl)
		else $error("no clock after start");
	a_stop_free: assert property (stop_ev |-> !dev_sda_oe [*8])
		else $error("device busy after stop");
	c_read_end: cover property (ack_slot && rd_ff && byte_ff == 3'h2);
	c_write_end: cover property (ack_slot && !rd_ff && byte_ff == 3'h3);
	c_stop: cover property (stop_ev);
endmodule : charger_assertions
`default_nettype wire

// ===== testbench.sv
// Self-checking bench: master and charger slave joined by the link
`timescale 1ns/1ps
`default_nettype none
`include "charger_map.svh"
module testbench import charger_pkg::*;;
	// Arbitrary identification values
	localparam logic [15:0] MAKER = 16'h3c21;
	localparam logic [15:0] PART = 16'h0017;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic charger_enable = 1'b1;
	logic adapter_present = 1'b1;
	logic thermal_fault = 1'b0;
	logic adapter_overvoltage_fault = 1'b0;
	logic adapter_overcurrent_fault = 1'b0;
	logic pwm_demand = 1'b1;
	logic charging, pass_switch_drive, analog_rail, gate_supply, high_side_gate, low_side_gate;
	logic [10:0] voltage_code;
	logic [5:0] current_code;
	int miscompares = 0;
	int comparisons = 0;
	smbus_link_if u_smbus_link_if();
	charger_master u_charger_master (.ref_clk, .rstn, .link(u_smbus_link_if), .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	charger_slave #(.MAKER_ID(MAKER), .PART_ID(PART)) u_charger_slave (.ref_clk, .rstn,
		.link(u_smbus_link_if), .charger_enable, .adapter_present, .thermal_fault,
		.adapter_overvoltage_fault, .adapter_overcurrent_fault, .pwm_demand, .charging,
		.pass_switch_drive, .analog_rail, .gate_supply, .high_side_gate, .low_side_gate,
		.voltage_code, .current_code);
	charger_assertions u_charger_assertions (.ref_clk, .rstn,
		.host_sda_oe(u_smbus_link_if.host_sda_oe), .dev_sda_oe(u_smbus_link_if.dev_sda_oe),
		.scl(u_smbus_link_if.scl), .sda(u_smbus_link_if.sda));
	initial forever #12.5 ref_clk = ~ref_clk;
	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk16
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wt
	// Every call assigns once and waits one edge, so strobes can run back to back
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
	endtask : bus
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] q);
		bus(1'b0, 1'b1, a, 16'h0000);
		reg_rd <= 1'b0;
		// Read data stand only in the cycle after the strobe; take them mid-cycle
		@(negedge ref_clk);
		q = reg_rdata;
		@(posedge ref_clk);
	endtask : rd_reg
	task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [15:0] d,
		output logic [15:0] q);
		logic [15:0] s;
		bus(1'b1, 1'b0, `HOST_DATA, d);
		bus(1'b1, 1'b0, `HOST_CTRL, {7'h00, rd, cmd});
		s = 16'h0001;
		for (int i = 0; i < 3000 && s[0] !== 1'b0; i++) rd_reg(`HOST_STATUS, s);
		if (s[0] !== 1'b0) begin
			miscompares++;
			$display("[ERR] %0t transfer hung", $time);
			print_verdict();
		end
		chk1(s[1], 1'b0);
		rd_reg(`HOST_DATA, q);
	endtask : xfer
	initial begin
		logic [15:0] q;
		wt(4);
		rstn <= 1'b1;
		wt(4);
		chk1(charging, 1'b0);
		chk16({5'h00, voltage_code}, 16'h0000);
		chk16({10'h000, current_code}, 16'h0000);
		rd_reg(4'h7, q);
		chk16(q, 16'h0000);
		xfer(1'b1, `CMD_MAKER, 16'h0000, q);
		chk16(q, MAKER);
		xfer(1'b0, `CMD_MAKER, 16'hffff, q);
		xfer(1'b1, `CMD_MAKER, 16'h0000, q);
		chk16(q, MAKER);
		xfer(1'b1, `CMD_PART, 16'h0000, q);
		chk16(q, PART);
		xfer(1'b1, 8'h3d, 16'h0000, q);
		chk16(q, 16'h0000);
		xfer(1'b0, `CMD_VOLTAGE, 16'hffff, q);
		xfer(1'b1, `CMD_VOLTAGE, 16'h0000, q);
		chk16(q, 16'h7ff0);
		chk16({5'h00, voltage_code}, 16'h07ff);
		chk1(charging, 1'b0);
		xfer(1'b0, `CMD_CURRENT, 16'hffff, q);
		xfer(1'b1, `CMD_CURRENT, 16'h0000, q);
		chk16(q, 16'h1f80);
		chk16({10'h000, current_code}, 16'h003f);
		wt(2);
		chk1(charging, 1'b1);
		chk1(high_side_gate, 1'b1);
		pwm_demand <= 1'b0;
		wt(5);
		chk1(low_side_gate, 1'b1);
		pwm_demand <= 1'b1;
		xfer(1'b0, `CMD_VOLTAGE, 16'h0ff0, q);
		wt(5);
		chk1(charging, 1'b0);
		xfer(1'b0, `CMD_VOLTAGE, 16'h1000, q);
		wt(5);
		chk1(charging, 1'b1);
		adapter_overvoltage_fault <= 1'b1;
		wt(5);
		chk1(pass_switch_drive, 1'b0);
		chk1(analog_rail, 1'b1);
		chk1(high_side_gate, 1'b0);
		adapter_overvoltage_fault <= 1'b0;
		wt(5);
		chk1(charging, 1'b1);
		// Only the fourth overcurrent event may latch
		for (int i = 1; i <= 4; i++) begin
			adapter_overcurrent_fault <= 1'b1;
			wt(5);
			chk1(charging, 1'b0);
			adapter_overcurrent_fault <= 1'b0;
			wt(5);
			chk1(analog_rail, i < 4);
			chk1(charging, i < 4);
		end
		chk1(gate_supply, 1'b0);
		xfer(1'b1, `CMD_VOLTAGE, 16'h0000, q);
		chk16(q, 16'h0000);
		adapter_present <= 1'b0;
		wt(5);
		adapter_present <= 1'b1;
		wt(5);
		chk1(analog_rail, 1'b1);
		chk1(charging, 1'b0);
		xfer(1'b0, `CMD_VOLTAGE, 16'h2000, q);
		xfer(1'b0, `CMD_CURRENT, 16'h0080, q);
		wt(5);
		chk1(charging, 1'b1);
		thermal_fault <= 1'b1;
		wt(5);
		thermal_fault <= 1'b0;
		wt(5);
		chk1(charging, 1'b0);
		chk1(pass_switch_drive, 1'b0);
		chk1(analog_rail, 1'b0);
		chk1(high_side_gate | low_side_gate, 1'b0);
		adapter_present <= 1'b0;
		wt(5);
		adapter_present <= 1'b1;
		wt(5);
		xfer(1'b0, `CMD_VOLTAGE, 16'h2000, q);
		charger_enable <= 1'b0;
		wt(5);
		charger_enable <= 1'b1;
		wt(5);
		xfer(1'b1, `CMD_VOLTAGE, 16'h0000, q);
		chk16(q, 16'h0000);
		// Mid-run reset must clear both settings and stop the charger
		xfer(1'b0, `CMD_VOLTAGE, 16'h2000, q);
		xfer(1'b0, `CMD_CURRENT, 16'h0080, q);
		wt(5);
		chk1(charging, 1'b1);
		rstn <= 1'b0;
		wt(4);
		rstn <= 1'b1;
		wt(4);
		chk1(charging, 1'b0);
		chk16({5'h00, voltage_code}, 16'h0000);
		chk16({10'h000, current_code}, 16'h0000);
		print_verdict();
	end
	initial begin
		wt(90000);
		miscompares++;
		$display("[ERR] %0t run limit reached", $time);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
